// *** hdl/asf_adc_status_flags.v ***
// ADC status and interrupt flag bank with a classic Wishbone slave port.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.vh"

// Behaviour
// R1: Reading the status register clears the conversion error flag.
// R2: Underrange or overrange of the current converter sets the conversion error flag.
// R3: Reading the result register clears the interrupt flag at status bit 6.
// R4: Always-interrupt mode raises the interrupt flag every conversion period, settled or not.
// R5: Default filter setting 0x0007 gives a 1.0 ms interrupt interval.
// R6: Ready flags stay clear for the first two interrupts after reconfiguration.
// R7: Software checks ready flags on each interrupt to judge result validity.
// R8: Reconfiguring the converter restarts the interrupt timing.
// R9: Accumulator magnitude above its threshold sets status bit 5.
// R10: Reconfiguration or accumulator comparator disable clears bit 5.
// R11: Enabled result comparator sets bit 4 when result magnitude exceeds threshold.
// R12: Reconfiguration or result comparator disable clears bit 4.
// R13: With the threshold counter, bit 4 sets only after that many exceeding conversions.
// R14: The fast overrange flag sits at status bit 3.
// R15: All converter interrupt sources are ORed into one interrupt request.
// R16: With overrange detection on, the fast overrange flag updates every 125 us.
// R17: Software changes the gain setting to clear the fast overrange flag.
// R18: Reserved status bits 11 to 7 read zero and ignore writes.
module asf_adc_status_flags #(
	parameter PERIOD_CYCLES = `ASF_PERIOD_CYCLES,
	parameter OVR_CYCLES    = `ASF_OVR_CYCLES
) (
	input  wire        clock,
	input  wire        arst_n,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [23:0] conv_result,
	input  wire [31:0] conv_accum,
	input  wire        conv_range_error,
	input  wire        input_overrange,
	input  wire [3:0]  gain_setting,
	output wire        irq
);

	// ------------------------------------------------------------------------
	// Sized constants
	// ------------------------------------------------------------------------
	// Sized copies keep each product and compare at the width of its register.
	// The period grows in steps of one eighth of the nominal default period.
	localparam [31:0] PERIOD_STEP = PERIOD_CYCLES / 8;
	localparam [31:0] OVR_LAST    = OVR_CYCLES - 1;

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	// Masking with ack stops a strobe still held in the ack cycle from starting again.
	wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr     = access & wb_we_i;
	wire rd     = access & ~wb_we_i;

	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr == off);
		end
	endfunction

	function [31:0] magnitude;
		input [31:0] v;
		begin
			magnitude = v[31] ? (~v + 32'h0000_0001) : v;
		end
	endfunction

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	reg  [15:0] filter_config_reg;
	reg  [31:0] accum_threshold_reg;
	reg  [23:0] result_threshold_reg;
	reg  [7:0]  threshold_counter_reg;
	reg  [15:0] control;
	reg  [15:0] irq_enable;
	reg  [23:0] result_hold;

	// Any write to filter or control counts as reconfiguration of the converter.
	wire reconfig = wr & (hit(wb_adr_i, `ASF_OFF_FILTER) | hit(wb_adr_i, `ASF_OFF_CONTROL));
	wire always_mode = control[`ASF_CTL_ALWAYS];
	wire acc_en = control[`ASF_CTL_ACC_EN];
	wire th_en  = control[`ASF_CTL_TH_EN];
	wire ovr_en = control[`ASF_CTL_OVR_EN];
	wire run    = control[`ASF_CTL_RUN];

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			filter_config_reg     <= `ASF_RST_FILTER;
			accum_threshold_reg   <= 32'h0000_0000;
			result_threshold_reg  <= 24'h00_0000;
			threshold_counter_reg <= 8'h00;
			control               <= `ASF_RST_CONTROL;
			irq_enable            <= 16'h0000;
		end else if (wr) begin
			if (hit(wb_adr_i, `ASF_OFF_FILTER) && wb_sel_i[0])
				filter_config_reg <= wb_dat_i[15:0];
			if (hit(wb_adr_i, `ASF_OFF_ACC_TH))
				accum_threshold_reg <= wb_dat_i;
			if (hit(wb_adr_i, `ASF_OFF_RES_TH))
				result_threshold_reg <= wb_dat_i[23:0];
			if (hit(wb_adr_i, `ASF_OFF_TH_COUNT))
				threshold_counter_reg <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `ASF_OFF_CONTROL))
				control <= wb_dat_i[15:0];
			if (hit(wb_adr_i, `ASF_OFF_IRQ_ENABLE))
				irq_enable <= wb_dat_i[15:0];
		end
	end

	// ------------------------------------------------------------------------
	// Conversion timebase
	// ------------------------------------------------------------------------
	// The period scales with the filter setting; 0x0007 yields the default period.
	wire [31:0] period = PERIOD_STEP * ({16'h0000, filter_config_reg} + 32'h0000_0001); // R5
	reg  [31:0] tick_count;
	reg  [1:0]  settle_count;
	// Clearing the run bit rewinds the timebase just as a reconfiguration does.
	wire        conv_done = run & (tick_count >= period - 32'h0000_0001);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_count   <= 32'h0000_0000;
			settle_count <= 2'h0;
		end else if (reconfig || !run) begin
			tick_count   <= 32'h0000_0000; // R8
			settle_count <= 2'h0; // R6
		end else if (conv_done) begin
			tick_count <= 32'h0000_0000;
			if (settle_count != `ASF_SETTLE_IRQS)
				settle_count <= settle_count + 2'h1;
		end else begin
			tick_count <= tick_count + 32'h0000_0001;
		end
	end

	// Ready only from the third conversion onward; software must look at it.
	wire settled = (settle_count == `ASF_SETTLE_IRQS); // R6 R7
	wire res_exceed = magnitude({{8{conv_result[23]}}, conv_result})
	                  > {8'h00, result_threshold_reg};
	wire acc_exceed = magnitude(conv_accum) > accum_threshold_reg;

	// ------------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------------
	reg        current_conv_error;
	reg        adc_irq_flag;
	reg        result_ready_flags;
	reg        accum_threshold_exceeded;
	reg        result_threshold_exceeded;
	reg        fast_overrange_flag;
	reg  [7:0] exceed_count;
	reg  [3:0] gain_seen;
	reg  [31:0] ovr_timer;

	wire rd_status = rd & hit(wb_adr_i, `ASF_OFF_STATUS);
	wire rd_result = rd & hit(wb_adr_i, `ASF_OFF_RESULT);
	wire next_exceed_hit = (exceed_count + 8'h01 >= threshold_counter_reg);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			current_conv_error        <= 1'b0;
			adc_irq_flag              <= 1'b0;
			result_ready_flags        <= 1'b0;
			accum_threshold_exceeded  <= 1'b0;
			result_threshold_exceeded <= 1'b0;
			exceed_count              <= 8'h00;
			result_hold               <= 24'h00_0000;
		end else if (reconfig) begin
			// Reconfiguration wipes every flag except the fast overrange flag, so a stale conversion flag cannot survive it.
			current_conv_error        <= 1'b0;
			adc_irq_flag              <= 1'b0;
			result_ready_flags        <= 1'b0;
			accum_threshold_exceeded  <= 1'b0; // R10
			result_threshold_exceeded <= 1'b0; // R12
			exceed_count              <= 8'h00;
		end else begin
			// Set wins over a read clear in each flag below; a comparator disable wins over set.
			if (conv_done && conv_range_error)
				current_conv_error <= 1'b1; // R2
			else if (rd_status)
				current_conv_error <= 1'b0; // R1
			if (conv_done && (always_mode || settled))
				adc_irq_flag <= 1'b1; // R4
			else if (rd_result)
				adc_irq_flag <= 1'b0; // R3
			if (conv_done && settled)
				result_ready_flags <= 1'b1;
			else if (rd_result)
				result_ready_flags <= 1'b0;
			if (conv_done && settled)
				result_hold <= conv_result;
			if (!acc_en)
				accum_threshold_exceeded <= 1'b0; // R10
			else if (conv_done && acc_exceed)
				accum_threshold_exceeded <= 1'b1; // R9
			if (!th_en) begin
				result_threshold_exceeded <= 1'b0; // R12
				exceed_count              <= 8'h00;
			end else if (conv_done) begin
				if (res_exceed) begin
					if (next_exceed_hit)
						result_threshold_exceeded <= 1'b1; // R11 R13
					else
						exceed_count <= exceed_count + 8'h01; // R13
				end else begin
					// One conversion under the threshold restarts the count.
					exceed_count <= 8'h00;
				end
			end
		end
	end

	// Fast overrange is sampled on its own 125 us grid; a gain change clears it.
	// The grid runs free, so the first sample after enabling may come early.
	wire ovr_tick = (ovr_timer == OVR_LAST);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fast_overrange_flag <= 1'b0;
			ovr_timer           <= 32'h0000_0000;
			gain_seen           <= `ASF_RST_GAIN;
		end else begin
			gain_seen <= gain_setting;
			ovr_timer <= ovr_tick ? 32'h0000_0000 : ovr_timer + 32'h0000_0001;
			if (ovr_en && ovr_tick && input_overrange)
				fast_overrange_flag <= 1'b1; // R16
			else if (gain_seen != gain_setting)
				fast_overrange_flag <= 1'b0; // R17
		end
	end

	// Bits 11 to 7 and the others not named stay zero.
	wire [15:0] status_word = {3'h0, current_conv_error, 5'h00, // R18
		adc_irq_flag, accum_threshold_exceeded, result_threshold_exceeded,
		fast_overrange_flag, 2'h0, result_ready_flags}; // R14

	// ------------------------------------------------------------------------
	// Sticky interrupt status
	// ------------------------------------------------------------------------
	// Events latch on a rising flag, so a flag that stays high reports once.
	reg  [15:0] irq_status;
	reg  [15:0] prev_status;
	wire [15:0] rise = status_word & ~prev_status;
	wire [15:0] clr  = (wr && hit(wb_adr_i, `ASF_OFF_IRQ_CLEAR)) ? wb_dat_i[15:0] : 16'h0000;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_status  <= 16'h0000;
			prev_status <= 16'h0000;
		end else begin
			prev_status <= status_word;
			irq_status  <= rise | (irq_status & ~clr);
		end
	end

	assign irq = |(irq_status & irq_enable); // R15

	// ------------------------------------------------------------------------
	// Read mux and acknowledge
	// ------------------------------------------------------------------------
	// Read data is zero outside an acknowledge, so slaves can share an ORed bus.
	reg [31:0] next_rdata;

	always @* begin
		case (wb_adr_i)
			`ASF_OFF_STATUS:     next_rdata = {16'h0000, status_word};
			`ASF_OFF_RESULT:     next_rdata = {8'h00, result_hold};
			`ASF_OFF_FILTER:     next_rdata = {16'h0000, filter_config_reg};
			`ASF_OFF_ACC_TH:     next_rdata = accum_threshold_reg;
			`ASF_OFF_RES_TH:     next_rdata = {8'h00, result_threshold_reg};
			`ASF_OFF_TH_COUNT:   next_rdata = {24'h00_0000, threshold_counter_reg};
			`ASF_OFF_CONTROL:    next_rdata = {16'h0000, control};
			`ASF_OFF_IRQ_STATUS: next_rdata = {16'h0000, irq_status};
			`ASF_OFF_IRQ_ENABLE: next_rdata = {16'h0000, irq_enable};
			default:             next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= rd ? next_rdata : 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// *** hdl/asf_regs.vh ***
// Register map, field positions, reset values and timing counts of the ADC status flag bank.
`ifndef ASF_REGS_VH
`define ASF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ASF_OFF_STATUS      8'h00
`define ASF_OFF_RESULT      8'h04
`define ASF_OFF_FILTER      8'h08
`define ASF_OFF_ACC_TH      8'h0c
`define ASF_OFF_RES_TH      8'h10
`define ASF_OFF_TH_COUNT    8'h14
`define ASF_OFF_CONTROL     8'h18
`define ASF_OFF_IRQ_STATUS  8'h1c
`define ASF_OFF_IRQ_CLEAR   8'h20
`define ASF_OFF_IRQ_ENABLE  8'h24

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define ASF_BIT_ERR         12
`define ASF_BIT_INT         6
`define ASF_BIT_ATH         5
`define ASF_BIT_TH          4
`define ASF_BIT_OVR         3
`define ASF_BIT_RDY         0

// ----------------------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------------------
`define ASF_CTL_ALWAYS      0
`define ASF_CTL_ACC_EN      1
`define ASF_CTL_TH_EN       2
`define ASF_CTL_OVR_EN      3
`define ASF_CTL_RUN         4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ASF_RST_FILTER      16'h0007
`define ASF_RST_CONTROL     16'h0000
`define ASF_RST_GAIN        4'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ASF_CLK_MHZ         100
`define ASF_PERIOD_US_DEF   1000
`define ASF_OVR_US          125
`define ASF_OVR_CYCLES      (`ASF_OVR_US * `ASF_CLK_MHZ)
`define ASF_PERIOD_CYCLES   (`ASF_PERIOD_US_DEF * `ASF_CLK_MHZ)
`define ASF_SETTLE_IRQS     2

`endif

// *** tb/asf_adc_status_flags_properties.sv ***
// Assertions on the bus port and interrupt output of the status flag bank.
`timescale 1ns/1ps
`default_nettype none
module asf_props (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire rd = wb_ack_o && !wb_we_i;
	property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_take: assert property (p_take) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data outside ack");
	property p_rsv; rd && wb_adr_i == 8'h00 |-> (wb_dat_o & ~32'h1079) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("status spare bits set");
	property p_rsvi; rd && wb_adr_i == 8'h1c |-> (wb_dat_o & ~32'h1079) == 32'h0; endproperty
	a_rsvi: assert property (p_rsvi) else $error("event spare bits set");
	property p_unm; rd && (wb_adr_i > 8'h24 || wb_adr_i == 8'h20) |-> wb_dat_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_mask; wb_ack_o && wb_we_i && wb_adr_i == 8'h24 && wb_dat_i[12:0] == 13'h0 |-> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
endmodule
bind asf_adc_status_flags asf_props i_props (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
`default_nettype wire

// *** tb/asf_conv_model.sv ***
// Converter front end feeding results and accumulator values to the flag bank.
`timescale 1ns/1ps
`default_nettype none
module asf_conv_model (
	input wire logic    clock,
	input wire logic    big,
	output logic [23:0] conv_result,
	output logic [31:0] conv_accum
);
	integer seed = 32'h8e1e;
	// Small values stay under any bench threshold; big ones are negative to test the magnitude.
	always @(posedge clock) begin
		conv_result <= big ? 24'hc00000 : {16'h0, 8'($random(seed))};
		conv_accum <= big ? 32'hfff00000 : {24'h0, 8'($random(seed))};
	end
endmodule
`default_nettype wire

// *** tb/test_asf_adc_status_flags.sv ***
// Self-checking bench of the ADC status flag bank.
`timescale 1ns/1ps
`default_nettype none
module test_asf_adc_status_flags;
	localparam PER = 80;
	logic        clock = 0, arst_n = 0, cyc = 0, we = 0, big = 0, err = 0, ovr = 0, ack, irq, irq_q;
	logic [7:0]  adr = 0;
	logic [3:0]  gain = 0;
	logic [23:0] res;
	logic [31:0] wdat = 0, rdat, dat_o, acc, thr;
	integer      n_errors = 0, total_checks = 0, seed = 32'h8e1e, cnt = 0, t_rise = 0, tp, k, i;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cnt <= cnt + 1;
		irq_q <= irq;
		if (irq && !irq_q)
			t_rise <= cnt;
	end
	asf_adc_status_flags #(.PERIOD_CYCLES(PER), .OVR_CYCLES(10)) i_dut (.clock(clock),
		.arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.conv_result(res), .conv_accum(acc), .conv_range_error(err),
		.input_overrange(ovr), .gain_setting(gain), .irq(irq));
	asf_conv_model i_conv (.clock(clock), .big(big), .conv_result(res), .conv_accum(acc));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task guard;
		if (i >= 300) begin
			n_errors++;
			end_sim;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (ack !== 1 && i < 300);
		guard;
		rdat = dat_o;
		cyc <= 0;
	endtask
	task wait_irq;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (irq !== 1 && i < 300);
		guard;
	endtask
	// Ready shows from the third event after a change of setup; thresholds only in pass one.
	function logic [31:0] exp_st(input integer k, input integer p);
		return 32'h40 | (k >= 3) | (p ? (32'h1020 | ((k >= 3) << 4)) : 32'h0);
	endfunction
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1;
		bus(0, 8'h08, 0);
		chk("filter", rdat, 32'h7);
		bus(1, 8'h00, 32'hffffffff);
		bus(0, 8'h00, 0);
		chk("status", rdat, 0);
		bus(0, 8'h30, 0);
		chk("unmapped", rdat, 0);
		$display("register test done");
		for (int p = 0; p < 2; p++) begin
			thr = 32'h100 + ($random(seed) & 32'hff);
			bus(1, 8'h0c, thr);
			bus(1, 8'h10, thr);
			bus(1, 8'h14, 3);
			bus(1, 8'h24, 32'h40);
			big <= p[0];
			err <= p[0];
			bus(1, 8'h18, p ? 32'h1f : 32'h11);
			tp = cnt;
			for (k = 1; k <= 4; k++) begin
				wait_irq;
				bus(0, 8'h00, 0);
				chk("flags", rdat & 32'h1071, exp_st(k, p));
				if (k > 1)
					chk("period", t_rise - tp, PER / 8 * 8);
				else
					chk("restart", t_rise - tp, PER / 8 * 8 + 1);
				tp = t_rise;
				bus(0, 8'h04, 0);
				bus(0, 8'h00, 0);
				chk("cleared", rdat & 32'h1040, 0);
				bus(1, 8'h20, 32'hffff);
				chk("irq", irq, 0);
			end
			$display("pass %0d done", p);
		end
		// Without always mode the first event waits for the settled third conversion.
		bus(1, 8'h18, 32'h18);
		tp = cnt;
		wait_irq;
		bus(0, 8'h00, 0);
		chk("quiet_flags", rdat & 32'h1071, 32'h1041);
		bus(0, 8'h1c, 0);
		chk("events", rdat, 32'h1041);
		chk("quiet_wait", t_rise - tp, 3 * (PER / 8 * 8) + 1);
		$display("quiet mode test done");
		ovr <= 1;
		repeat (25) @(posedge clock);
		bus(0, 8'h00, 0);
		chk("fast_ovr", rdat & 32'h8, 32'h8);
		ovr <= 0;
		gain <= 4'h5;
		bus(0, 8'h00, 0);
		chk("ovr_clear", rdat & 32'h8, 0);
		bus(1, 8'h24, 0);
		chk("irq_off", irq, 0);
		$display("overrange test done");
		end_sim;
	end
endmodule
`default_nettype wire
